/* File: hw/dsp_macro_pkg.sv */
// Package for the DSP arithmetic macro: widths, register map and modes.
// Assumes a single fabric clock and plain register port access.
package dsp_macro_pkg;

    // Datapath widths
    localparam int OP_W   = 18;             // Pre-adder operand width
    localparam int HALF_W = 9;              // Narrow lane width
    localparam int PRE_W  = 19;             // Pre-adder result width
    localparam int ALU_W  = 54;             // Arithmetic unit width
    localparam int MP_W   = 72;             // Packed multiplier result

    // Register port
    localparam int ADDR_W = 4;              // Register address width
    localparam int DATA_W = 32;             // Register data width
    localparam logic [3:0] ADDR_CTRL   = 4'h0; // Configuration
    localparam logic [3:0] ADDR_RES_LO = 4'h4; // Arithmetic result [31:0]
    localparam logic [3:0] ADDR_RES_HI = 4'h8; // Arithmetic result [53:32]
    localparam logic [3:0] ADDR_MUL_LO = 4'hc; // Multiplier result [31:0]
    localparam int CTRL_W      = 19;        // Configuration field width, clear bit included
    localparam int ACC_CLR_BIT = 18;        // Write-one accumulator clear
    localparam int RES_HI_W    = 22;        // Upper result slice width

    // Multiplier split
    typedef enum logic [1:0] {
        MUL_18X18 = 2'b00,                  // Two independent 18 x 18
        MUL_9X9   = 2'b01,                  // Four independent 9 x 9
        MUL_18X36 = 2'b11,                  // One 18 x 36
        MUL_36X36 = 2'b10                   // Upper half of a 36 x 36 pair
    } mult_mode_t;

    // Pre-adder function
    typedef enum logic [1:0] {
        PRE_PASS  = 2'b00,                  // Operand A straight through
        PRE_ADD   = 2'b01,                  // A + B
        PRE_SUB   = 2'b11,                  // A - B
        PRE_SHIFT = 2'b10                   // A shifted left by one
    } pre_op_t;

    // Arithmetic unit operand set
    typedef enum logic [1:0] {
        SET_MAB = 2'b00,                    // Product, A, B
        SET_MBC = 2'b01,                    // Product, B, carry C
        SET_ABC = 2'b11                     // A, B, carry C
    } alu_set_t;

    // Operating mode
    typedef enum logic [1:0] {
        OPM_MULT    = 2'b00,                // Plain multiply
        OPM_MAC     = 2'b01,                // Multiply-accumulate
        OPM_MADDACC = 2'b11                 // Multiply-add-accumulate
    } op_mode_t;

    // Configuration word, bit 0 upward from mult_mode
    typedef struct packed {
        logic       alu_reg;                // [17] Arithmetic output registered
        logic       mul_reg;                // [16] Multiplier output registered
        logic       in_reg;                 // [15] Operand inputs registered
        logic       chain_b;                // [14] B from shift chain
        logic       chain_a;                // [13] A from shift chain
        logic       pre_w9;                 // [12] Pre-adders in 9-bit lanes
        pre_op_t    pre1_op;                // [11:10]
        pre_op_t    pre0_op;                // [9:8]
        op_mode_t   op_mode;                // [7:6]
        logic       mult_zero;              // [5] Force product term to zero
        logic       alu_sub;                // [4] Subtract instead of add
        alu_set_t   alu_set;                // [3:2]
        mult_mode_t mult_mode;              // [1:0]
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = 18'h00000; // All bypass, plain multiply

    // Fabric operands for both pre-adders and multipliers
    typedef struct packed {
        logic [17:0] a0;                    // Pre-adder 0 operand A
        logic [17:0] b0;                    // Pre-adder 0 operand B
        logic [17:0] c0;                    // Multiplier 0 second operand
        logic [17:0] a1;                    // Pre-adder 1 operand A
        logic [17:0] b1;                    // Pre-adder 1 operand B
        logic [17:0] c1;                    // Multiplier 1 second operand
    } macro_in_t;

endpackage

/* File: hw/dsp_macro_mult_alu.sv */
// DSP arithmetic macro: two pre-adders, two multipliers, one wide adder.
// Assumes fabric operands on the same clock and a plain register port.
//
// Summary of operation
// - Two pre-adders, two 18x18 multipliers, three-input adder
// - Pre-adder adds, subtracts or shifts
// - Pre-adder inputs parallel or shift chain
// - All pre-adder inputs registered or bypassed together
// - Pre-adder usable alone, 9 or 18 bits
// - Split as 18x36, two 18x18, four 9x9
// - Two macros combine into 36x36 multiplier
// - Multiplier and adder ports registered or bypassed
// - Arithmetic unit is 54 bits wide
// - Adder takes one of three operand sets
// - Multiply, accumulate, multiply-add-accumulate modes
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

module dsp_macro_mult_alu (
    input  wire logic                  clk,               // Fabric clock
    input  wire logic                  rstn,              // Sync reset
    input  wire logic [3:0]            reg_addr,          // Register address
    input  wire logic [31:0]           reg_wdata,         // Write data
    input  wire logic                  reg_wr,            // Write strobe
    input  wire logic                  reg_rd,            // Read strobe
    output logic      [31:0]           reg_rdata,         // Read data
    input  wire dsp_macro_pkg::macro_in_t din,            // Fabric operands
    input  wire logic [17:0]           shift_chain_in_a,  // Chain A in
    input  wire logic [17:0]           shift_chain_in_b,  // Chain B in
    input  wire logic [53:0]           alu_a,             // Adder operand A
    input  wire logic [53:0]           alu_b,             // Adder operand B
    input  wire logic [53:0]           alu_c,             // Adder carry C
    input  wire logic [53:0]           casc_in,           // Partner product
    output logic      [17:0]           shift_chain_out_a, // Chain A out
    output logic      [17:0]           shift_chain_out_b, // Chain B out
    output logic      [18:0]           pre_out0,          // Pre-adder 0 result
    output logic      [18:0]           pre_out1,          // Pre-adder 1 result
    output logic      [71:0]           mult_out,          // Packed products
    output logic      [53:0]           casc_out,          // Product to partner
    output logic      [53:0]           alu_out            // Adder result
);

    localparam int OP_W  = dsp_macro_pkg::OP_W;
    localparam int HW    = dsp_macro_pkg::HALF_W;
    localparam int ALU_W = dsp_macro_pkg::ALU_W;
    localparam int MP_W  = dsp_macro_pkg::MP_W;

    dsp_macro_pkg::ctrl_t ctrl_reg;          // Stored configuration
    logic                 acc_clr_reg;       // One-cycle accumulator clear

    logic [OP_W-1:0]  a_sel [2];             // Chosen operand A
    logic [OP_W-1:0]  b_sel [2];             // Chosen operand B
    logic [OP_W-1:0]  c_sel [2];             // Multiplier second operand
    logic [OP_W-1:0]  a_reg [2];             // Registered operand A
    logic [OP_W-1:0]  b_reg [2];             // Registered operand B
    logic [OP_W-1:0]  c_reg [2];             // Registered operand C
    logic [OP_W-1:0]  a_st  [2];             // Operand A after reg/bypass
    logic [OP_W-1:0]  b_st  [2];             // Operand B after reg/bypass
    logic [OP_W-1:0]  c_st  [2];             // Operand C after reg/bypass
    logic [18:0]      pre_res [2];           // Pre-adder results

    logic [MP_W-1:0]  mult_raw;              // Products before stage
    logic [MP_W-1:0]  mult_reg;              // Product register
    logic [MP_W-1:0]  mult_st;               // Products after reg/bypass
    logic [ALU_W-1:0] m54;                   // Product term for adder
    logic [ALU_W-1:0] opx;                   // First adder operand
    logic [ALU_W-1:0] opsum;                 // Second plus third operand
    logic [ALU_W-1:0] alu_res;               // Adder result
    logic [ALU_W-1:0] acc_reg;               // Adder output register
    logic [ALU_W-1:0] alu_st;                // Adder result after stage

    // Pre-adder core: full 18-bit or two independent 9-bit lanes
    function automatic logic [18:0] pre_calc(
        input logic [17:0]           a,
        input logic [17:0]           b,
        input dsp_macro_pkg::pre_op_t op,
        input logic                  w9
    );
        logic [18:0] full;
        logic [9:0]  lo;
        logic [9:0]  hi;
        case (op)
            dsp_macro_pkg::PRE_ADD: begin
                full = {1'b0, a} + {1'b0, b};
                lo   = {1'b0, a[HW-1:0]} + {1'b0, b[HW-1:0]};
                hi   = {1'b0, a[OP_W-1:HW]} + {1'b0, b[OP_W-1:HW]};
            end
            dsp_macro_pkg::PRE_SUB: begin
                full = {1'b0, a} - {1'b0, b};
                lo   = {1'b0, a[HW-1:0]} - {1'b0, b[HW-1:0]};
                hi   = {1'b0, a[OP_W-1:HW]} - {1'b0, b[OP_W-1:HW]};
            end
            dsp_macro_pkg::PRE_SHIFT: begin
                full = {a, 1'b0};
                lo   = {a[HW-1:0], 1'b0};
                hi   = {a[OP_W-1:HW], 1'b0};
            end
            default: begin
                full = {1'b0, a};
                lo   = {1'b0, a[HW-1:0]};
                hi   = {1'b0, a[OP_W-1:HW]};
            end
        endcase
        // Narrow lanes drop their carries so lanes stay independent
        return w9 ? {1'b0, hi[HW-1:0], lo[HW-1:0]} : full;
    endfunction

    // Configuration register and accumulator clear pulse
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_reg    <= dsp_macro_pkg::CTRL_RESET;
            acc_clr_reg <= 1'b0;
        end else begin
            acc_clr_reg <= reg_wr && (reg_addr == dsp_macro_pkg::ADDR_CTRL)
                           && reg_wdata[dsp_macro_pkg::ACC_CLR_BIT];
            // Clear bit is not stored, it only pulses
            if (reg_wr && (reg_addr == dsp_macro_pkg::ADDR_CTRL)) begin
                ctrl_reg <= dsp_macro_pkg::ctrl_t'(
                    reg_wdata[dsp_macro_pkg::CTRL_W-2:0]);
            end
        end
    end

    // Read port: data stand one cycle after the strobe, else zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                dsp_macro_pkg::ADDR_CTRL:   reg_rdata <= 32'(ctrl_reg);
                dsp_macro_pkg::ADDR_RES_LO: reg_rdata <= acc_reg[31:0];
                dsp_macro_pkg::ADDR_RES_HI: reg_rdata <= 32'(acc_reg >> 32);
                dsp_macro_pkg::ADDR_MUL_LO: reg_rdata <= mult_st[31:0];
                default:                    reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Operand selection and input stage, one copy per pre-adder
    for (genvar k = 0; k < 2; k++) begin : g_pre
        logic [OP_W-1:0] a_par;              // Parallel operand A
        logic [OP_W-1:0] b_par;              // Parallel operand B
        logic [OP_W-1:0] c_par;              // Parallel operand C
        logic [OP_W-1:0] a_chn;              // Chain operand A
        logic [OP_W-1:0] b_chn;              // Chain operand B
        assign a_par = (k == 0) ? din.a0 : din.a1;
        assign b_par = (k == 0) ? din.b0 : din.b1;
        assign c_par = (k == 0) ? din.c0 : din.c1;
        // Second stage chains from the first stage's registered operands
        assign a_chn = (k == 0) ? shift_chain_in_a : a_reg[0];
        assign b_chn = (k == 0) ? shift_chain_in_b : b_reg[0];
        assign a_sel[k] = ctrl_reg.chain_a ? a_chn : a_par;
        assign b_sel[k] = ctrl_reg.chain_b ? b_chn : b_par;
        assign c_sel[k] = c_par;

        // Input registers load every cycle, bypass picks the live value
        always_ff @(posedge clk) begin
            if (!rstn) begin
                a_reg[k] <= 18'h00000;
                b_reg[k] <= 18'h00000;
                c_reg[k] <= 18'h00000;
            end else begin
                a_reg[k] <= a_sel[k];
                b_reg[k] <= b_sel[k];
                c_reg[k] <= c_sel[k];
            end
        end

        assign a_st[k] = ctrl_reg.in_reg ? a_reg[k] : a_sel[k];
        assign b_st[k] = ctrl_reg.in_reg ? b_reg[k] : b_sel[k];
        assign c_st[k] = ctrl_reg.in_reg ? c_reg[k] : c_sel[k];
        assign pre_res[k] = pre_calc(a_st[k], b_st[k],
            (k == 0) ? ctrl_reg.pre0_op : ctrl_reg.pre1_op,
            ctrl_reg.pre_w9);
    end

    // Multipliers: split or combined according to the mode
    always_comb begin
        logic [53:0] p1836;
        p1836 = 54'(pre_res[0][OP_W-1:0]) * 54'({c_st[1], c_st[0]});
        case (ctrl_reg.mult_mode)
            dsp_macro_pkg::MUL_18X18: begin
                mult_raw = {36'(pre_res[1][OP_W-1:0]) * 36'(c_st[1]),
                            36'(pre_res[0][OP_W-1:0]) * 36'(c_st[0])};
            end
            dsp_macro_pkg::MUL_9X9: begin
                mult_raw = {
                    18'(pre_res[1][OP_W-1:HW]) * 18'(c_st[1][OP_W-1:HW]),
                    18'(pre_res[1][HW-1:0])    * 18'(c_st[1][HW-1:0]),
                    18'(pre_res[0][OP_W-1:HW]) * 18'(c_st[0][OP_W-1:HW]),
                    18'(pre_res[0][HW-1:0])    * 18'(c_st[0][HW-1:0])};
            end
            dsp_macro_pkg::MUL_18X36: begin
                mult_raw = 72'(p1836);
            end
            default: begin
                // Upper half of A here, partner supplies the lower half
                mult_raw = (72'(p1836) << OP_W) + 72'(casc_in);
            end
        endcase
    end

    // Multiplier output stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mult_reg <= 72'h0;
        end else begin
            mult_reg <= mult_raw;
        end
    end

    assign mult_st = ctrl_reg.mul_reg ? mult_reg : mult_raw;

    // Product term for the adder, summed across split lanes
    always_comb begin
        case (ctrl_reg.mult_mode)
            dsp_macro_pkg::MUL_18X18:
                m54 = 54'(mult_st[35:0]) + 54'(mult_st[71:36]);
            dsp_macro_pkg::MUL_9X9:
                m54 = 54'(mult_st[17:0])  + 54'(mult_st[35:18])
                    + 54'(mult_st[53:36]) + 54'(mult_st[71:54]);
            default:
                m54 = mult_st[ALU_W-1:0];
        endcase
        if (ctrl_reg.mult_zero) begin
            m54 = 54'h0;
        end
    end

    // Operand sets: first term, and the sum of the other two
    always_comb begin
        case (ctrl_reg.alu_set)
            dsp_macro_pkg::SET_MAB: begin
                opx   = m54;
                opsum = alu_a + alu_b;
            end
            dsp_macro_pkg::SET_MBC: begin
                opx   = m54;
                opsum = alu_b + alu_c;
            end
            default: begin
                opx   = alu_a;
                opsum = alu_b + alu_c;
            end
        endcase
    end

    // Arithmetic unit: plain, or running sum from its own register
    always_comb begin
        case (ctrl_reg.op_mode)
            dsp_macro_pkg::OPM_MAC: begin
                alu_res = ctrl_reg.alu_sub ? acc_reg - m54 : acc_reg + m54;
            end
            dsp_macro_pkg::OPM_MADDACC: begin
                alu_res = ctrl_reg.alu_sub ? acc_reg - (opx + opsum)
                                           : acc_reg + (opx + opsum);
            end
            default: begin
                alu_res = ctrl_reg.alu_sub ? opx - opsum : opx + opsum;
            end
        endcase
    end

    // Adder output register, also the accumulator
    always_ff @(posedge clk) begin
        if (!rstn) begin
            acc_reg <= 54'h0;
        end else if (acc_clr_reg) begin
            acc_reg <= 54'h0;
        end else begin
            acc_reg <= alu_res;
        end
    end

    assign alu_st = ctrl_reg.alu_reg ? acc_reg : alu_res;

    // Output flops towards the fabric and the neighbouring macro
    always_ff @(posedge clk) begin
        if (!rstn) begin
            shift_chain_out_a <= 18'h00000;
            shift_chain_out_b <= 18'h00000;
            pre_out0          <= 19'h00000;
            pre_out1          <= 19'h00000;
            mult_out          <= 72'h0;
            casc_out          <= 54'h0;
            alu_out           <= 54'h0;
        end else begin
            shift_chain_out_a <= a_sel[1];
            shift_chain_out_b <= b_sel[1];
            pre_out0          <= pre_res[0];
            pre_out1          <= pre_res[1];
            mult_out          <= mult_st;
            casc_out          <= mult_st[ALU_W-1:0];
            alu_out           <= alu_st;
        end
    end

    // Checks kept beside the logic

    a_pre_add_reg: assert property (
        @(posedge clk) disable iff (!rstn)
        ctrl_reg.in_reg && !ctrl_reg.pre_w9
        && ctrl_reg.pre0_op == dsp_macro_pkg::PRE_ADD
        && $stable(ctrl_reg) |->
        pre_res[0] == {1'b0, $past(a_sel[0])} + {1'b0, $past(b_sel[0])})
        else $error("pre-adder sum wrong with registered inputs");

    a_chain_feed: assert property (
        @(posedge clk) disable iff (!rstn)
        ctrl_reg.chain_a && !reg_wr |=>
        a_reg[0] == $past(shift_chain_in_a))
        else $error("chain input not taken");

    a_in_stage: assert property (
        @(posedge clk) disable iff (!rstn)
        ctrl_reg.in_reg ##1 ctrl_reg.in_reg |->
        a_st[1] == $past(a_sel[1]) && b_st[1] == $past(b_sel[1]))
        else $error("input register not one cycle late");

    a_pre_narrow: assert property (
        @(posedge clk) disable iff (!rstn)
        ctrl_reg.pre_w9 && ctrl_reg.pre1_op == dsp_macro_pkg::PRE_ADD |=>
        pre_out1 == $past({1'b0,
            9'(a_st[1][17:9] + b_st[1][17:9]),
            9'(a_st[1][8:0] + b_st[1][8:0])}))
        else $error("narrow lanes not independent");

    a_mult_split: assert property (
        @(posedge clk) disable iff (!rstn)
        ctrl_reg.mult_mode == dsp_macro_pkg::MUL_18X18
        && !ctrl_reg.mul_reg |=>
        mult_out[35:0] == $past(36'(pre_res[0][17:0]) * 36'(c_st[0])))
        else $error("18x18 product wrong");

    a_mult_wide: assert property (
        @(posedge clk) disable iff (!rstn)
        ctrl_reg.mult_mode == dsp_macro_pkg::MUL_36X36
        && !ctrl_reg.mul_reg |=>
        mult_out == $past((72'(pre_res[0][17:0])
            * 72'({c_st[1], c_st[0]}) << 18) + 72'(casc_in)))
        else $error("combined product wrong");

    a_mul_stage: assert property (
        @(posedge clk) disable iff (!rstn)
        ctrl_reg.mul_reg && $stable(ctrl_reg) |->
        ##1 mult_out == $past(mult_raw, 2))
        else $error("product stage latency wrong");

    a_alu_sets: assert property (
        @(posedge clk) disable iff (!rstn)
        ctrl_reg.op_mode == dsp_macro_pkg::OPM_MULT
        && ctrl_reg.alu_set == dsp_macro_pkg::SET_MAB
        && !ctrl_reg.alu_sub && !acc_clr_reg |=>
        acc_reg == $past(m54 + alu_a + alu_b))
        else $error("adder operand set wrong");

    a_acc_loop: assert property (
        @(posedge clk) disable iff (!rstn)
        ctrl_reg.op_mode == dsp_macro_pkg::OPM_MAC && ctrl_reg.alu_sub
        && !acc_clr_reg |=>
        acc_reg == $past(acc_reg) - $past(m54))
        else $error("accumulator not fed back");

    a_read_late: assert property (
        @(posedge clk) disable iff (!rstn)
        reg_rd && reg_addr == dsp_macro_pkg::ADDR_RES_HI |=>
        reg_rdata == 32'($past(acc_reg[53:32])))
        else $error("upper result read wrong");

endmodule // dsp_macro_mult_alu

/* File: dv/fabric_user.sv */
// Fabric-side user logic model that feeds operands into the macro.
// Assumes one fabric clock; operands change only just after an edge.
`timescale 1ns/1ps
module fabric_user (
    input  wire logic             clk, // Fabric clock
    output dsp_macro_pkg::macro_in_t din, // Multiplier operands
    output logic [53:0]           opa, // Adder operand A
    output logic [53:0]           opb, // Adder operand B
    output logic [53:0]           opc  // Adder carry C
);
    // Idle operands from time zero
    initial begin
        din = '0;
        opa = '0;
        opb = '0;
        opc = '0;
    end
    // Present one operand set just after an edge, held until next call
    task automatic put(input dsp_macro_pkg::macro_in_t v,
                       input logic [53:0] a, b, c);
        @(posedge clk);
        din <= v;
        opa <= a;
        opb <= b;
        opc <= c;
    endtask
endmodule // fabric_user

/* File: dv/tb.sv */
// Self-checking bench for the arithmetic macro.
// Assumes 25 MHz clock, sync active-low reset, all-bypass reset config.
`timescale 1ns/1ps
module tb;
    logic        clk, rstn, reg_wr, reg_rd;  // Clock, reset, strobes
    logic [3:0]  reg_addr;                   // Register address
    logic [31:0] reg_wdata, reg_rdata;       // Register data
    logic [17:0] ch_a, ch_b, so_a, so_b;     // Shift chain in and out
    logic [18:0] pre0, pre1;                 // Pre-adder results
    logic [71:0] mult;                       // Packed products
    logic [53:0] a, b, c, casc, cout, alu;   // Adder side
    dsp_macro_pkg::macro_in_t din, v;        // Operands
    dsp_macro_pkg::ctrl_t     cf;            // Configuration word
    logic [18:0] pe[4] = '{19'd10, 19'd14, 19'd20, 19'd6}; // Per pre op
    int miscompares, num_checks;
    fabric_user fab (.clk(clk), .din(din), .opa(a), .opb(b), .opc(c));
    dsp_macro_mult_alu DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .din(din), .shift_chain_in_a(ch_a),
        .shift_chain_in_b(ch_b), .alu_a(a), .alu_b(b), .alu_c(c),
        .casc_in(casc), .shift_chain_out_a(so_a), .shift_chain_out_b(so_b),
        .pre_out0(pre0), .pre_out1(pre1), .mult_out(mult),
        .casc_out(cout), .alu_out(alu));
    // Verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Compare a datapath result
    task automatic chk_dp(input logic [71:0] g, e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t data got %h exp %h", $time, g, e);
        end
    endtask
    // Register write, one strobe cycle
    task automatic wr(input logic [3:0] ad, input logic [31:0] wd);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= wd;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Register read, data judged in the cycle after the strobe
    task automatic rd(input logic [3:0] ad, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk_dp(72'(reg_rdata), 72'(e));
    endtask
    task automatic cfg(input logic clr);
        wr(dsp_macro_pkg::ADDR_CTRL, {13'h0, clr, cf});
    endtask
    // Present operands, then settle lat edges later
    task automatic go(input int lat, input logic [53:0] x, y, z);
        fab.put(v, x, y, z);
        repeat (lat) @(posedge clk);
        #1;
    endtask
    task automatic alu1(input dsp_macro_pkg::alu_set_t s, input logic sb,
                        input logic [53:0] e);
        cf.alu_set = s;
        cf.alu_sub = sb;
        cfg(1'b0);
        go(1, 54'd100, 54'd20, 54'd3);
        chk_dp(72'(alu), 72'(e));
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Main sequence
    initial begin
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {ch_b, casc, cf, v, miscompares, num_checks} = '0;
        ch_a = 18'd77;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd(dsp_macro_pkg::ADDR_CTRL, 32'h0);
        rd(4'h2, 32'h0);
        cf.alu_reg = 1'b1;
        cfg(1'b1);
        rd(dsp_macro_pkg::ADDR_CTRL, 32'h0002_0000);
        cf = '0;
        cfg(1'b0);
        v.a0 = 18'd3; v.c0 = 18'd5; v.a1 = 18'd7; v.c1 = 18'd9;
        go(1, 0, 0, 0);
        chk_dp(mult, {36'd63, 36'd15});
        chk_dp(72'(cout), 72'({18'd63, 36'd15}));
        rd(dsp_macro_pkg::ADDR_MUL_LO, 32'd15);
        cf.mult_mode = dsp_macro_pkg::MUL_9X9;
        cfg(1'b0);
        v = '0; v.a0 = {9'd2, 9'd3}; v.c0 = {9'd4, 9'd5};
        go(1, 0, 0, 0);
        chk_dp(mult, {36'd0, 18'd8, 18'd15});
        cf.mult_mode = dsp_macro_pkg::MUL_18X36;
        cfg(1'b0);
        v = '0; v.a0 = 18'd3; v.c0 = 18'd2; v.c1 = 18'd1;
        go(1, 0, 0, 0);
        chk_dp(mult, 72'd786438);
        cf.mult_mode = dsp_macro_pkg::MUL_36X36;
        cfg(1'b0);
        @(posedge clk);
        casc <= 54'd5;
        go(1, 0, 0, 0);
        chk_dp(mult, (72'd786438 << 18) + 72'd5);
        cf = '0; v = '0; v.a0 = 18'd10; v.b0 = 18'd4;
        for (int i = 0; i < 4; i++) begin
            cf.pre0_op = dsp_macro_pkg::pre_op_t'(i[1:0]);
            cfg(1'b0);
            go(1, 0, 0, 0);
            chk_dp(72'(pre0), 72'(pe[i]));
        end
        cf.pre0_op = dsp_macro_pkg::PRE_ADD; cf.pre_w9 = 1'b1;
        cf.pre1_op = dsp_macro_pkg::PRE_ADD;
        cfg(1'b0);
        v.a0 = {9'd1, 9'd511}; v.b0 = {9'd1, 9'd1};
        v.a1 = v.a0; v.b1 = v.b0;
        go(1, 0, 0, 0);
        chk_dp(72'(pre0), 72'd1024);
        chk_dp(72'(pre1), 72'd1024);
        cf = '0; cf.chain_a = 1'b1;
        cfg(1'b0);
        go(1, 0, 0, 0);
        chk_dp(72'(pre0), 72'd77);
        chk_dp(72'(so_a), 72'd77);
        chk_dp(72'(pre1), 72'd77);
        cf = '0; cf.in_reg = 1'b1; cf.pre0_op = dsp_macro_pkg::PRE_ADD;
        cfg(1'b0);
        v = '0; v.a0 = 18'd33; v.c0 = 18'd2;
        go(1, 0, 0, 0);
        chk_dp(72'(pre0), 72'd1536);
        @(posedge clk);
        #1 chk_dp(72'(pre0), 72'd33);
        chk_dp(mult, 72'd66);
        cf = '0; cf.mul_reg = 1'b1; cf.alu_reg = 1'b1;
        cfg(1'b0);
        v.a0 = 18'd4;
        go(1, 0, 0, 0);
        chk_dp(mult, 72'd66);
        @(posedge clk);
        #1 chk_dp(mult, 72'd8);
        chk_dp(72'(alu), 72'd66);
        cf = '0; v = '0; v.a0 = 18'd2; v.c0 = 18'd3;
        alu1(dsp_macro_pkg::SET_MAB, 1'b0, 54'd126);
        alu1(dsp_macro_pkg::SET_MBC, 1'b0, 54'd29);
        alu1(dsp_macro_pkg::SET_ABC, 1'b0, 54'd123);
        alu1(dsp_macro_pkg::SET_ABC, 1'b1, 54'd77);
        cf.mult_zero = 1'b1;
        alu1(dsp_macro_pkg::SET_MAB, 1'b0, 54'd120);
        cf = '0; cf.op_mode = dsp_macro_pkg::OPM_MAC; v = '0;
        go(1, 0, 0, 0);
        cfg(1'b1);
        v.a0 = 18'd2; v.c0 = 18'd3;
        fab.put(v, 0, 0, 0);
        repeat (4) @(posedge clk);
        v = '0;
        fab.put(v, 0, 0, 0);
        rd(dsp_macro_pkg::ADDR_RES_LO, 32'd30);
        cf.alu_sub = 1'b1;
        cfg(1'b0);
        v.a0 = 18'd2; v.c0 = 18'd3;
        fab.put(v, 0, 0, 0);
        cf.op_mode = dsp_macro_pkg::OPM_MADDACC; cf.alu_sub = 1'b0;
        cfg(1'b0);
        v.a0 = 18'd2; v.c0 = 18'd3;
        fab.put(v, 54'h20_0000_0000_0000, 0, 0);
        v = '0;
        fab.put(v, 0, 0, 0);
        rd(dsp_macro_pkg::ADDR_RES_LO, 32'd30);
        rd(dsp_macro_pkg::ADDR_RES_HI, 32'h0020_0000);
        test_done;
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        test_done;
    end
endmodule // tb
